// [ascii_port_pkg.sv]
package ascii_port_pkg;
    // register offsets on the plain port
    localparam logic [3:0]  REG_TERM_TYPE  = 4'h0;
    localparam logic [3:0]  REG_RX_BASE    = 4'h1;
    localparam logic [3:0]  REG_TX_BASE    = 4'h2;
    localparam logic [3:0]  REG_TERM_CNT   = 4'h3;
    localparam logic [3:0]  REG_TERM_CHARS = 4'h4;
    localparam logic [3:0]  REG_PKT_LIMIT  = 4'h5;
    localparam logic [3:0]  REG_MSG_TMO    = 4'h6;
    localparam logic [3:0]  REG_GAP_TMO    = 4'h7;
    localparam logic [3:0]  REG_STATUS     = 4'h8;
    // termination type bit positions
    localparam int          TT_CHAR        = 0;
    localparam int          TT_MSG         = 1;
    localparam int          TT_GAP         = 2;
    localparam int          TT_SIZE        = 3;
    localparam logic [7:0]  TT_USED_MASK   = 8'h0F;
    // reset values
    localparam logic [15:0] BASE_DISABLED  = 16'hFFFF;
    localparam logic [7:0]  RST_TERM_TYPE  = 8'h00;
    localparam logic [2:0]  RST_TERM_CNT   = 3'h0;
    localparam logic [7:0]  RST_PKT_LIMIT  = 8'h00;
    localparam logic [15:0] RST_TMO_MS     = 16'h0000;
    // buffer and receive block layout
    localparam int          RX_BUF_DEPTH   = 255;
    localparam logic [7:0]  RX_BUF_FULL    = 8'hFF;
    localparam logic [15:0] RX_WORD_SEQ    = 16'h0000;
    localparam logic [15:0] RX_WORD_LEN    = 16'h0002;
    localparam logic [15:0] RX_WORD_DATA   = 16'h0009;
    // millisecond tick
    localparam int          CLK_HZ         = 100_000_000;
    localparam int          MS_NS          = 1_000_000;
    localparam int          CLK_NS         = 1_000_000_000 / CLK_HZ;
    localparam int          MS_CYCLES      = MS_NS / CLK_NS;
    localparam logic [16:0] MS_CNT_LAST    = 17'(MS_CYCLES - 1);
endpackage

// [ascii_port_rx_framer.sv]
// Chosen here: the plain strobed port and the address map.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - one instance per port, nothing shared
// - transmit base all ones: no new block starts, one in progress finishes
// - receive base all ones: drop input
// - new transmit sequence value starts sending
// - 255-byte buffer, copied out on termination
// - type bits: char, message, gap, size
// - type zero streams each character out
// - any mix of conditions works together
// - terminator forwarded with preceding characters
// - message timer starts at first character
// - gap timer restarts on each character
// - forward whenever size limit reached
// - data and length first, sequence last
// - length word 2, data words 9 on
// - nonzero delay paces transmit in milliseconds
module ascii_port_rx_framer
    import ascii_port_pkg::*;
(
    input  wire logic        core_clk_in,
    input  wire logic        srst_in,
    // register port
    input  wire logic [3:0]  reg_addr_in,
    input  wire logic [31:0] reg_wdata_in,
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    output logic      [31:0] reg_rdata_out,
    // characters from the serial receiver
    input  wire logic [7:0]  rx_char_in,
    input  wire logic        rx_char_valid_in,
    output logic             rx_char_ready_out,
    // database write side
    output logic             db_wr_out,
    output logic      [15:0] db_addr_out,
    output logic      [15:0] db_wdata_out,
    input  wire logic        db_ready_in,
    // transmit block fields read from the database
    input  wire logic [15:0] tx_seq_in,
    input  wire logic [15:0] tx_delay_ms_in,
    input  wire logic [7:0]  tx_count_in,
    output logic      [6:0]  tx_index_out,
    input  wire logic [15:0] tx_word_in,
    // characters to the serial transmitter
    output logic      [7:0]  tx_char_out,
    output logic             tx_char_valid_out,
    input  wire logic        tx_char_ready_in
);

    typedef enum logic [3:0] {
        RX_COLLECT = 4'b0001,
        RX_DATA    = 4'b0010,
        RX_LEN     = 4'b0100,
        RX_SEQ     = 4'b1000
    } rx_state_e;

    typedef enum logic [2:0] {
        TX_IDLE  = 3'b001,
        TX_SEND  = 3'b010,
        TX_PAUSE = 3'b100
    } tx_state_e;

    // configuration registers
    logic [7:0]  term_type_ff;
    logic [15:0] rx_base_ff;
    logic [15:0] tx_base_ff;
    logic [2:0]  term_cnt_ff;
    logic [31:0] term_chars_ff;
    logic [7:0]  pkt_limit_ff;
    logic [15:0] msg_tmo_ff;
    logic [15:0] gap_tmo_ff;

    // receive path state
    rx_state_e   rx_state_ff;
    logic [7:0]  rx_buf [RX_BUF_DEPTH];
    logic [7:0]  fill_ff;
    logic [7:0]  out_idx_ff;
    logic [15:0] rx_seq_ff;
    logic [15:0] msg_ms_ff;
    logic [15:0] gap_ms_ff;
    logic [16:0] ms_cnt_ff;
    logic        ms_tick;

    // two-entry skid buffer toward the database
    logic [15:0] skid_addr [2];
    logic [15:0] skid_data [2];
    logic        skid_wp_ff;
    logic        skid_rp_ff;
    logic [1:0]  skid_cnt_ff;
    logic        push;
    logic [15:0] push_addr;
    logic [15:0] push_data;
    logic        pop;

    // transmit path state
    tx_state_e   tx_state_ff;
    logic [15:0] tx_seq_seen_ff;
    logic [7:0]  tx_pos_ff;
    logic [15:0] tx_wait_ff;

    logic        rx_on;
    logic        tx_on;
    logic        take;
    logic        is_term;
    logic        close_msg;
    logic        stream;

    function automatic logic match_term(input logic [7:0]  ch,
                                        input logic [31:0] set,
                                        input logic [2:0]  cnt);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < 4; i++)
        begin
            if (i < int'(cnt) && set[i*8 +: 8] == ch)
            begin
                hit = 1'b1;
            end
        end
        return hit;
    endfunction

    assign rx_on  = (rx_base_ff != BASE_DISABLED);
    assign tx_on  = (tx_base_ff != BASE_DISABLED);
    assign stream = ((term_type_ff & TT_USED_MASK) == 8'h00);

    // characters are drained when disabled so the receiver never stalls
    assign rx_char_ready_out = (rx_state_ff == RX_COLLECT) || !rx_on;
    assign take    = rx_char_valid_in && rx_char_ready_out && rx_on;
    assign is_term = term_type_ff[TT_CHAR] && match_term(rx_char_in, term_chars_ff, term_cnt_ff);

    // any satisfied condition closes the message; all conditions live at once
    always_comb
    begin
        close_msg = 1'b0;
        if (take && (stream || is_term))
            close_msg = 1'b1;
        if (take && term_type_ff[TT_SIZE] && (fill_ff + 8'h01) >= pkt_limit_ff)
            close_msg = 1'b1;
        if (take && fill_ff == RX_BUF_FULL - 8'h01)
            close_msg = 1'b1;
        if (!take && fill_ff != 8'h00 && ms_tick)
        begin
            if (term_type_ff[TT_MSG] && msg_ms_ff + 16'h0001 >= msg_tmo_ff)
                close_msg = 1'b1;
            if (term_type_ff[TT_GAP] && gap_ms_ff + 16'h0001 >= gap_tmo_ff)
                close_msg = 1'b1;
        end
    end

    // free-running millisecond tick
    assign ms_tick = (ms_cnt_ff == MS_CNT_LAST);
    always_ff @(posedge core_clk_in)
    begin
        if (srst_in || ms_tick)
            ms_cnt_ff <= 17'h00000;
        else
            ms_cnt_ff <= ms_cnt_ff + 17'h00001;
    end

    // register writes
    always_ff @(posedge core_clk_in)
    begin
        if (srst_in)
        begin
            term_type_ff  <= RST_TERM_TYPE;
            rx_base_ff    <= BASE_DISABLED;
            tx_base_ff    <= BASE_DISABLED;
            term_cnt_ff   <= RST_TERM_CNT;
            term_chars_ff <= 32'h00000000;
            pkt_limit_ff  <= RST_PKT_LIMIT;
            msg_tmo_ff    <= RST_TMO_MS;
            gap_tmo_ff    <= RST_TMO_MS;
        end
        else if (reg_wr_in)
        begin
            if (reg_addr_in == REG_TERM_TYPE)
                term_type_ff <= reg_wdata_in[7:0];
            else if (reg_addr_in == REG_RX_BASE)
                rx_base_ff <= reg_wdata_in[15:0];
            else if (reg_addr_in == REG_TX_BASE)
                tx_base_ff <= reg_wdata_in[15:0];
            else if (reg_addr_in == REG_TERM_CNT)
                term_cnt_ff <= reg_wdata_in[2:0];
            else if (reg_addr_in == REG_TERM_CHARS)
                term_chars_ff <= reg_wdata_in;
            else if (reg_addr_in == REG_PKT_LIMIT)
                pkt_limit_ff <= reg_wdata_in[7:0];
            else if (reg_addr_in == REG_MSG_TMO)
                msg_tmo_ff <= reg_wdata_in[15:0];
            else if (reg_addr_in == REG_GAP_TMO)
                gap_tmo_ff <= reg_wdata_in[15:0];
        end
    end

    // register reads, data one cycle later; unmapped reads zero
    always_ff @(posedge core_clk_in)
    begin
        if (srst_in)
            reg_rdata_out <= 32'h00000000;
        else if (!reg_rd_in)
            reg_rdata_out <= 32'h00000000;
        else if (reg_addr_in == REG_TERM_TYPE)
            reg_rdata_out <= {24'h000000, term_type_ff};
        else if (reg_addr_in == REG_RX_BASE)
            reg_rdata_out <= {16'h0000, rx_base_ff};
        else if (reg_addr_in == REG_TX_BASE)
            reg_rdata_out <= {16'h0000, tx_base_ff};
        else if (reg_addr_in == REG_TERM_CNT)
            reg_rdata_out <= {29'h00000000, term_cnt_ff};
        else if (reg_addr_in == REG_TERM_CHARS)
            reg_rdata_out <= term_chars_ff;
        else if (reg_addr_in == REG_PKT_LIMIT)
            reg_rdata_out <= {24'h000000, pkt_limit_ff};
        else if (reg_addr_in == REG_MSG_TMO)
            reg_rdata_out <= {16'h0000, msg_tmo_ff};
        else if (reg_addr_in == REG_GAP_TMO)
            reg_rdata_out <= {16'h0000, gap_tmo_ff};
        else if (reg_addr_in == REG_STATUS)
            reg_rdata_out <= {rx_seq_ff, fill_ff, 4'h0, tx_state_ff != TX_IDLE, rx_state_ff != RX_COLLECT,
                              tx_on, rx_on};
        else
            reg_rdata_out <= 32'h00000000;
    end

    // buffer writes, one character per accepted strobe
    always_ff @(posedge core_clk_in)
    begin
        if (take)
            rx_buf[fill_ff] <= rx_char_in;
    end

    // message and gap timers, restarted per message and per character
    always_ff @(posedge core_clk_in)
    begin
        if (srst_in || take || close_msg || fill_ff == 8'h00)
        begin
            gap_ms_ff <= 16'h0000;
        end
        else if (ms_tick)
        begin
            gap_ms_ff <= gap_ms_ff + 16'h0001;
        end
        if (srst_in || close_msg || fill_ff == 8'h00)
            msg_ms_ff <= 16'h0000;
        else if (ms_tick)
            msg_ms_ff <= msg_ms_ff + 16'h0001;
    end

    // receive block writer: data words, then length, then sequence
    always_comb
    begin
        push      = 1'b0;
        push_addr = 16'h0000;
        push_data = 16'h0000;
        if (skid_cnt_ff != 2'd2)
        begin
            if (rx_state_ff == RX_DATA)
            begin
                push      = 1'b1;
                push_addr = rx_base_ff + RX_WORD_DATA + {8'h00, out_idx_ff};
                push_data = {8'h00, rx_buf[out_idx_ff]};
            end
            else if (rx_state_ff == RX_LEN)
            begin
                push      = 1'b1;
                push_addr = rx_base_ff + RX_WORD_LEN;
                push_data = {8'h00, fill_ff};
            end
            else if (rx_state_ff == RX_SEQ)
            begin
                push      = 1'b1;
                push_addr = rx_base_ff + RX_WORD_SEQ;
                push_data = rx_seq_ff + 16'h0001;
            end
        end
    end

    always_ff @(posedge core_clk_in)
    begin
        if (srst_in)
        begin
            rx_state_ff <= RX_COLLECT;
            fill_ff     <= 8'h00;
            out_idx_ff  <= 8'h00;
            rx_seq_ff   <= 16'h0000;
        end
        else
        begin
            case (rx_state_ff)
                RX_COLLECT:
                begin
                    if (take)
                        fill_ff <= fill_ff + 8'h01;
                    if (close_msg)
                    begin
                        out_idx_ff  <= 8'h00;
                        rx_state_ff <= RX_DATA;
                    end
                end
                RX_DATA:
                begin
                    if (push)
                    begin
                        out_idx_ff <= out_idx_ff + 8'h01;
                        if (out_idx_ff + 8'h01 == fill_ff)
                            rx_state_ff <= RX_LEN;
                    end
                end
                RX_LEN:
                begin
                    if (push)
                        rx_state_ff <= RX_SEQ;
                end
                RX_SEQ:
                begin
                    if (push)
                    begin
                        rx_seq_ff   <= rx_seq_ff + 16'h0001;
                        fill_ff     <= 8'h00;
                        rx_state_ff <= RX_COLLECT;
                    end
                end
                default:
                    rx_state_ff <= RX_COLLECT;
            endcase
        end
    end

    // skid buffer so a stalled database loses no word
    assign pop          = (skid_cnt_ff != 2'd0) && db_ready_in;
    assign db_wr_out    = (skid_cnt_ff != 2'd0);
    assign db_addr_out  = skid_addr[skid_rp_ff];
    assign db_wdata_out = skid_data[skid_rp_ff];
    always_ff @(posedge core_clk_in)
    begin
        if (srst_in)
        begin
            skid_wp_ff  <= 1'b0;
            skid_rp_ff  <= 1'b0;
            skid_cnt_ff <= 2'd0;
        end
        else
        begin
            if (push)
            begin
                skid_addr[skid_wp_ff] <= push_addr;
                skid_data[skid_wp_ff] <= push_data;
                skid_wp_ff            <= ~skid_wp_ff;
            end
            if (pop)
                skid_rp_ff <= ~skid_rp_ff;
            skid_cnt_ff <= skid_cnt_ff + {1'b0, push} - {1'b0, pop};
        end
    end

    // transmitter: byte pairs low byte first, paced by the delay word
    assign tx_index_out      = tx_pos_ff[7:1];
    assign tx_char_out       = tx_pos_ff[0] ? tx_word_in[15:8] : tx_word_in[7:0];
    assign tx_char_valid_out = (tx_state_ff == TX_SEND);
    always_ff @(posedge core_clk_in)
    begin
        if (srst_in)
        begin
            tx_state_ff    <= TX_IDLE;
            tx_seq_seen_ff <= 16'h0000;
            tx_pos_ff      <= 8'h00;
            tx_wait_ff     <= 16'h0000;
        end
        else
        begin
            case (tx_state_ff)
                TX_IDLE:
                begin
                    tx_seq_seen_ff <= tx_seq_in;
                    if (tx_on && tx_seq_in != tx_seq_seen_ff && tx_count_in != 8'h00)
                    begin
                        tx_pos_ff   <= 8'h00;
                        tx_state_ff <= TX_SEND;
                    end
                end
                TX_SEND:
                begin
                    if (tx_char_ready_in)
                    begin
                        tx_pos_ff  <= tx_pos_ff + 8'h01;
                        tx_wait_ff <= 16'h0000;
                        if (tx_pos_ff + 8'h01 == tx_count_in)
                            tx_state_ff <= TX_IDLE;
                        else if (tx_delay_ms_in != 16'h0000)
                            tx_state_ff <= TX_PAUSE;
                    end
                end
                TX_PAUSE:
                begin
                    if (ms_tick)
                    begin
                        tx_wait_ff <= tx_wait_ff + 16'h0001;
                        if (tx_wait_ff + 16'h0001 >= tx_delay_ms_in)
                            tx_state_ff <= TX_SEND;
                    end
                end
                default:
                    tx_state_ff <= TX_IDLE;
            endcase
        end
    end

endmodule

`default_nettype wire

// [ascii_port_chk_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
module ascii_port_chk
    import ascii_port_pkg::*;
(
    input  wire logic        core_clk_in,
    input  wire logic        srst_in,
    input  wire logic [3:0]  reg_addr_in,
    input  wire logic [31:0] reg_wdata_in,
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    input  wire logic [31:0] reg_rdata_out,
    input  wire logic        rx_char_valid_in,
    input  wire logic        rx_char_ready_out,
    input  wire logic        db_wr_out,
    input  wire logic [15:0] db_addr_out,
    input  wire logic [15:0] db_wdata_out,
    input  wire logic        db_ready_in,
    input  wire logic [7:0]  tx_char_out,
    input  wire logic        tx_char_valid_out,
    input  wire logic        tx_char_ready_in
);
    logic [15:0] rx_base_ff;
    logic [15:0] tx_base_ff;
    logic [15:0] last_addr_ff;
    logic [7:0]  tt_ff;
    logic [7:0]  lim_ff;
    logic [7:0]  fill_ff;
    logic [7:0]  dcnt_ff;
    logic        rx_on;
    logic        take;
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (srst_in);

    // a char only counts when the framer really took it
    assign rx_on = rx_base_ff != BASE_DISABLED;
    assign take  = rx_char_valid_in && rx_char_ready_out && rx_on;

    // shadow of the settings the framer should hold
    always_ff @(posedge core_clk_in)
    begin
        if (srst_in)
        begin
            rx_base_ff <= BASE_DISABLED;
            tx_base_ff <= BASE_DISABLED;
            tt_ff      <= RST_TERM_TYPE;
            lim_ff     <= RST_PKT_LIMIT;
        end
        else if (reg_wr_in)
        begin
            if (reg_addr_in == REG_RX_BASE) rx_base_ff <= reg_wdata_in[15:0];
            if (reg_addr_in == REG_TX_BASE) tx_base_ff <= reg_wdata_in[15:0];
            if (reg_addr_in == REG_TERM_TYPE) tt_ff <= reg_wdata_in[7:0];
            if (reg_addr_in == REG_PKT_LIMIT) lim_ff <= reg_wdata_in[7:0];
        end
    end

    // chars of the open message; the buffer may still drain the last one
    always_ff @(posedge core_clk_in)
    begin
        if (srst_in || !rx_char_ready_out)
            fill_ff <= 8'h00;
        else if (take)
            fill_ff <= fill_ff + 8'h01;
    end

    // last word accepted, and data words since the last sequence word
    always_ff @(posedge core_clk_in)
    begin
        if (db_wr_out && db_ready_in)
            last_addr_ff <= db_addr_out;
        if (srst_in || (db_wr_out && db_ready_in && db_addr_out == rx_base_ff))
            dcnt_ff <= 8'h00;
        else if (db_wr_out && db_ready_in && db_addr_out >= rx_base_ff + RX_WORD_DATA)
            dcnt_ff <= dcnt_ff + 8'h01;
    end

    sequence s_word(logic [15:0] a);
        db_wr_out && db_ready_in && db_addr_out == a;
    endsequence

    AST_RDATA_IDLE: assert property (!reg_rd_in |=> reg_rdata_out == 32'h0)
        else $error("read data not zero outside read answer");
    AST_TX_OFF: assert property (tx_base_ff == BASE_DISABLED |-> !tx_char_valid_out)
        else $error("transmit while transmit disabled");
    AST_RX_OFF_WR: assert property (!rx_on |-> !db_wr_out)
        else $error("database write while receive disabled");
    AST_RX_OFF_RDY: assert property (!rx_on |-> rx_char_ready_out)
        else $error("input not discarded while receive disabled");
    AST_STREAM: assert property (take && tt_ff == 8'h00 |=> !rx_char_ready_out ##1 db_wr_out)
        else $error("stream char not forwarded at once");
    AST_SIZE: assert property (take && tt_ff[TT_SIZE] && fill_ff == lim_ff - 8'h01 |=> !rx_char_ready_out)
        else $error("size limit did not close block");
    AST_FULL: assert property (take && fill_ff == 8'hFE |=> !rx_char_ready_out)
        else $error("full buffer did not close block");
    AST_LEN: assert property (s_word(rx_base_ff + RX_WORD_LEN) |-> db_wdata_out == {8'h00, dcnt_ff})
        else $error("length word differs from chars taken");
    AST_SEQ_LAST: assert property (s_word(rx_base_ff) |-> last_addr_ff == rx_base_ff + RX_WORD_LEN)
        else $error("sequence word not after length word");
    AST_DB_HOLD: assert property (db_wr_out && !db_ready_in |=> db_wr_out && $stable(db_addr_out)
                                  && $stable(db_wdata_out))
        else $error("database word changed while stalled");
    AST_TX_HOLD: assert property (tx_char_valid_out && !tx_char_ready_in |=> tx_char_valid_out
                                  && $stable(tx_char_out))
        else $error("transmit char changed while stalled");
endmodule

bind ascii_port_rx_framer ascii_port_chk chk_u (.*);
`default_nettype wire

// [ascii_dev_model.sv]
`timescale 1ns/1ps
`default_nettype none
module ascii_dev_model (
    input  wire logic       core_clk_in,
    output logic      [7:0] rx_char_out,
    output logic            rx_valid_out,
    input  wire logic       rx_ready_in,
    input  wire logic [7:0] tx_char_in,
    input  wire logic       tx_valid_in,
    output logic            tx_ready_out
);
    logic [7:0] send_q[$];
    logic [7:0] got_q[$];
    logic       slow_mode;

    initial
    begin
        rx_char_out  = 8'h00;
        rx_valid_out = 1'b0;
        tx_ready_out = 1'b1;
        slow_mode    = 1'b0;
    end

    // char held until taken; idle line toggles so stale data never looks valid
    always @(posedge core_clk_in)
    begin
        if (rx_valid_out && rx_ready_in)
            void'(send_q.pop_front());
        if (send_q.size() != 0)
        begin
            rx_valid_out <= 1'b1;
            rx_char_out  <= send_q[0];
        end
        else
        begin
            rx_valid_out <= 1'b0;
            rx_char_out  <= ~rx_char_out;
        end
    end

    // slow terminal accepts every other cycle
    always @(posedge core_clk_in)
    begin
        if (tx_valid_in && tx_ready_out)
            got_q.push_back(tx_char_in);
        tx_ready_out <= slow_mode ? ~tx_ready_out : 1'b1;
    end
endmodule
`default_nettype wire

// [ascii_port_rx_framer_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module ascii_port_rx_framer_bench
    import ascii_port_pkg::*;
;
    typedef struct { logic [7:0] tt; logic [7:0] lim; logic [15:0] base; string s; } row_s;
    logic        core_clk_in, srst_in, reg_wr_in, reg_rd_in, rx_char_valid_in, rx_char_ready_out;
    logic        db_wr_out, db_ready_in, tx_char_valid_out, tx_char_ready_in;
    logic [3:0]  reg_addr_in;
    logic [31:0] reg_wdata_in, reg_rdata_out;
    logic [7:0]  rx_char_in, tx_char_out, tx_count_in;
    logic [15:0] db_addr_out, db_wdata_out, tx_seq_in, tx_word_in, tx_delay_ms_in;
    logic [6:0]  tx_index_out;
    logic [15:0] exp_q[$];
    logic [7:0]  q[$];
    int          n_errors, n_tests, cyc;
    row_s        rows[5] = '{
        '{8'h01, 8'h00, 16'h0100, "ABC\015DE"},
        '{8'h08, 8'h04, 16'h0200, "ABCDEFGHIJ"},
        '{8'h00, 8'h00, 16'h0300, "XY"},
        '{8'h09, 8'h03, 16'h0040, "A\015BCDE"},
        '{8'h01, 8'h00, BASE_DISABLED, "AB\015"}};

    ascii_port_rx_framer dut_u (.*);
    ascii_dev_model dev_u (.core_clk_in(core_clk_in), .rx_char_out(rx_char_in), .rx_valid_out(rx_char_valid_in),
        .rx_ready_in(rx_char_ready_out), .tx_char_in(tx_char_out), .tx_valid_in(tx_char_valid_out),
        .tx_ready_out(tx_char_ready_in));

    // transmit block text is A, B, C... low byte first
    assign tx_word_in = {8'h42 + {tx_index_out, 1'b0}, 8'h41 + {tx_index_out, 1'b0}};

    initial
    begin
        core_clk_in = 1'b0;
        forever #5 core_clk_in = ~core_clk_in;
    end

    // database stalls two cycles in three to exercise the buffer
    always @(posedge core_clk_in)
    begin
        cyc <= cyc + 1;
        db_ready_in <= (cyc % 3) == 0;
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp)
        begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // every accepted database word is matched against the plan
    always @(posedge core_clk_in)
    begin
        if (!srst_in && db_wr_out && db_ready_in)
        begin
            if (exp_q.size() < 2)
                chk("unexpected db write", 32'h0, {16'h0, db_addr_out});
            else
            begin
                chk("db addr", {16'h0, exp_q.pop_front()}, {16'h0, db_addr_out});
                chk("db data", {16'h0, exp_q.pop_front()}, {16'h0, db_wdata_out});
            end
        end
    end

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge core_clk_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge core_clk_in);
        reg_wr_in <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        @(posedge core_clk_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge core_clk_in);
        reg_rd_in <= 1'b0;
        #1 chk("reg read", exp, reg_rdata_out);
    endtask

    // expected words: data, then length, then sequence
    function automatic void plan(input logic [7:0] tt, lim, input logic [15:0] base, input logic [7:0] c[$]);
        logic [7:0]  hold_q[$];
        logic [15:0] seq;
        seq = 16'h0000;
        foreach (c[i])
        begin
            hold_q.push_back(c[i]);
            if (base != BASE_DISABLED && (tt == 8'h00 || (tt[TT_CHAR] && c[i] == 8'h0D)
                || (tt[TT_SIZE] && hold_q.size() == lim) || hold_q.size() == RX_BUF_DEPTH))
            begin
                foreach (hold_q[j])
                begin
                    exp_q.push_back(base + RX_WORD_DATA + 16'(j));
                    exp_q.push_back({8'h00, hold_q[j]});
                end
                seq++;
                exp_q.push_back(base + RX_WORD_LEN);
                exp_q.push_back(16'(hold_q.size()));
                exp_q.push_back(base + RX_WORD_SEQ);
                exp_q.push_back(seq);
                hold_q.delete();
            end
        end
    endfunction

    task automatic do_reset();
        srst_in <= 1'b1;
        repeat (3) @(posedge core_clk_in);
        srst_in <= 1'b0;
    endtask

    task automatic run(input logic [7:0] tt, lim, input logic [15:0] base);
        do_reset();
        wr(REG_TERM_TYPE, {24'h0, tt});
        wr(REG_PKT_LIMIT, {24'h0, lim});
        wr(REG_TERM_CNT, 32'h1);
        wr(REG_TERM_CHARS, 32'h0D);
        wr(REG_RX_BASE, {16'h0, base});
        plan(tt, lim, base, q);
        #1 foreach (q[i]) dev_u.send_q.push_back(q[i]);
        repeat (2000) if (exp_q.size() != 0 || dev_u.send_q.size() != 0) @(posedge core_clk_in);
        repeat (20) @(posedge core_clk_in);
        chk("words left", 32'h0, 32'(exp_q.size()));
    endtask

    // each run waits at most about 2000 cycles; this span only trips on a hang
    initial
    begin
        repeat (20000) @(posedge core_clk_in);
        n_errors++;
        give_verdict();
    end

    initial
    begin
        {srst_in, reg_wr_in, reg_rd_in, reg_addr_in, reg_wdata_in} = '0;
        {tx_seq_in, tx_count_in, tx_delay_ms_in, cyc, n_errors, n_tests} = '0;
        db_ready_in = 1'b0;
        foreach (rows[r])
        begin
            q.delete();
            for (int i = 0; i < rows[r].s.len(); i++)
                q.push_back(rows[r].s[i]);
            run(rows[r].tt, rows[r].lim, rows[r].base);
        end
        q.delete();
        repeat (256) q.push_back(8'h61);
        run(8'h01, 8'h00, 16'h0500);
        do_reset();
        rd(REG_TERM_TYPE, {24'h0, RST_TERM_TYPE});
        rd(REG_RX_BASE, {16'h0, BASE_DISABLED});
        rd(REG_TX_BASE, {16'h0, BASE_DISABLED});
        rd(4'hF, 32'h0);
        wr(REG_TERM_TYPE, 32'h0B);
        rd(REG_TERM_TYPE, 32'h0B);
        wr(REG_TX_BASE, 32'h0100);
        rd(REG_STATUS, 32'h2);
        dev_u.slow_mode = 1'b1;
        tx_count_in <= 8'h03;
        for (int k = 1; k < 3; k++)
        begin
            dev_u.got_q.delete();
            tx_seq_in <= 16'(k);
            repeat (100) @(posedge core_clk_in);
            chk("tx count", 32'h3, 32'(dev_u.got_q.size()));
            for (int i = 0; i < 3; i++)
                chk("tx char", 32'h41 + i, {24'h0, dev_u.got_q[i]});
        end
        wr(REG_TX_BASE, {16'h0, BASE_DISABLED});
        dev_u.got_q.delete();
        tx_seq_in <= 16'h0009;
        repeat (100) @(posedge core_clk_in);
        chk("tx off count", 32'h0, 32'(dev_u.got_q.size()));
        give_verdict();
    end
endmodule
`default_nettype wire
